// file: watch_interval_timer_tb.sv
// watch_interval_timer_tb: self-checking bench for the watch timer top.
// assumes wit_pkg and wit_watch_timer compile first; drives on falling edge.
module watch_interval_timer_tb import wit_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic reset = 1'b0;
	wit_write_type reg_wr = '0;
	logic [15:0] rd_addr = 16'h0000;
	logic [7:0] rd_data;
	logic main_clock_div2 = 1'b0;
	logic watch_clock_source_select = 1'b1;
	logic sub_clock_tick = 1'b0;
	logic watch_interrupt_mask = 1'b0;
	logic flag_clear = 1'b0;
	logic watch_interrupt_flag;
	logic interval_interrupt;
	logic standby_release;
	logic [4:0] counter_value;
	int err_total = 0;
	int n_tests = 0;
	int tp = 0;
	int tc = 0;
	int n, nf, m;
	logic [7:0] v, e, d;

	wit_watch_timer dut (
		.clk(clk),
		.reset(reset),
		.reg_wr(reg_wr),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.main_clock_div2(main_clock_div2),
		.watch_clock_source_select(watch_clock_source_select),
		.sub_clock_tick(sub_clock_tick),
		.watch_interrupt_mask(watch_interrupt_mask),
		.flag_clear(flag_clear),
		.watch_interrupt_flag(watch_interrupt_flag),
		.interval_interrupt(interval_interrupt),
		.standby_release(standby_release),
		.counter_value(counter_value)
	);

	// 100 mhz clock
	initial begin
		forever #5 clk = ~clk;
	end

	// subsystem tick every tp cycles; tp of 0 keeps the line quiet
	always @(negedge clk) begin
		if (tp == 0) begin
			sub_clock_tick <= 1'b0;
		end else begin
			tc = (tc + 1) % tp;
			sub_clock_tick <= (tc == 0);
		end
	end

	// cycles between interval requests for a code and tick spacing
	function automatic int ivl_cycles(input int code, input int per);
		return per << (4 + code);
	endfunction : ivl_cycles

	task automatic close_out();
		if (err_total == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one write strobe, byte or single bit, held for one edge
	task automatic wr(input logic b, input logic [2:0] s,
			input logic [7:0] dv, input logic [15:0] a);
		@(negedge clk);
		reg_wr <= {~b, b, s, dv, a};
		@(negedge clk);
		reg_wr <= '0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] q);
		@(negedge clk);
		rd_addr <= a;
		@(negedge clk);
		@(negedge clk);
		q = rd_data;
	endtask : rd

	// bounded wait; k comes back equal to lim when nothing happened
	task automatic wait_ev(input bit sel, input int lim, output int k);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (k < lim && (sel ? watch_interrupt_flag :
			interval_interrupt) !== 1'b1);
	endtask : wait_ev

	// restart the chain from zero and time the first flag
	task automatic flag_from(input logic [7:0] mode, output int k);
		watch_interrupt_mask <= 1'($urandom);
		// one prescaler clear per measurement only
		wr(1'b0, 3'h0, 8'h00, WIT_CTRL_ADDR);
		flag_clear <= 1'b1;
		@(negedge clk);
		flag_clear <= 1'b0;
		wr(1'b0, 3'h0, mode, WIT_CTRL_ADDR);
		wait_ev(1'b1, 40000, k);
		chk(standby_release, !watch_interrupt_mask);
	endtask : flag_from

	// main sequence
	initial begin
		void'($urandom(32'h62d4));
		// nba edge so the async reset branches see a rising reset
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		reset <= 1'b0;
		rd(WIT_CTRL_ADDR, v);
		chk(v, 8'h00);
		// random byte and bit writes, with a stray write elsewhere
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			wr(1'b0, 3'h0, d, WIT_CTRL_ADDR);
			e = d & 8'h7f;
			rd(WIT_CTRL_ADDR, v);
			chk(v, e);
			m = $urandom_range(7);
			wr(1'b1, 3'(m), {7'h00, d[6]}, WIT_CTRL_ADDR);
			e[m] = d[6];
			e = e & 8'h7f;
			wr(1'b0, 3'h0, ~d, WIT_CTRL_ADDR + 16'h0001);
			rd(WIT_CTRL_ADDR, v);
			chk(v, e);
		end
		rd(WIT_CTRL_ADDR + 16'h0001, v);
		chk(v, 8'h00);
		// every interval code from the subsystem tick, prohibited ones too
		tp = 2;
		for (int c = 0; c < 8; c++) begin
			wr(1'b0, 3'h0, {1'b0, 3'(c), 4'h2}, WIT_CTRL_ADDR);
			wait_ev(1'b0, 1200, n);
			wait_ev(1'b0, 1200, n);
			chk(n, (c < 6) ? ivl_cycles(c, 2) : 1200);
		end
		wr(1'b0, 3'h0, 8'h04, WIT_CTRL_ADDR);
		wait_ev(1'b0, 1200, n);
		chk(n, 1200);
		// main clock over 2^7, full rate then halved
		tp = 0;
		for (int h = 0; h < 2; h++) begin
			// stop the timer before touching the clock selection
			wr(1'b0, 3'h0, 8'h00, WIT_CTRL_ADDR);
			watch_clock_source_select <= 1'b0;
			main_clock_div2 <= h[0];
			wr(1'b0, 3'h0, 8'h02, WIT_CTRL_ADDR);
			wait_ev(1'b0, 9000, n);
			wait_ev(1'b0, 9000, n);
			chk(n, ivl_cycles(0, 128 << h));
		end
		// flag periods compared against fast feed, so latency cancels
		wr(1'b0, 3'h0, 8'h00, WIT_CTRL_ADDR);
		watch_clock_source_select <= 1'b1;
		tp = 1;
		flag_from(8'h07, nf);
		flag_from(8'h0e, n);
		chk(n - nf, (1 << 13) - (1 << 5));
		flag_from(8'h06, n);
		chk(n - nf, (1 << 14) - (1 << 5));
		// counter steps per 512 ticks and clears when its enable drops
		wr(1'b0, 3'h0, 8'h00, WIT_CTRL_ADDR);
		wr(1'b0, 3'h0, 8'h06, WIT_CTRL_ADDR);
		repeat (600) @(negedge clk);
		chk(counter_value, 5'h01);
		wr(1'b1, 3'h2, 8'h00, WIT_CTRL_ADDR);
		repeat (600) @(negedge clk);
		chk(counter_value, 5'h00);
		// second reset in mid-run
		wr(1'b0, 3'h0, 8'h7f, WIT_CTRL_ADDR);
		reset <= 1'b1;
		@(negedge clk);
		reset <= 1'b0;
		rd(WIT_CTRL_ADDR, v);
		chk(v, 8'h00);
		close_out();
	end

	// watchdog, well past the expected run of about 50k cycles
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		close_out();
	end

endmodule : watch_interval_timer_tb

// file: wit_clock_gen.sv
// wit_clock_gen: builds the watch clock enable from the main clock or a
// subsystem tick. assumes sub_clock_tick is a one-cycle pulse in clk domain.
module wit_clock_gen import wit_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// clock selection
	input wire logic main_clock_div2,
	input wire logic watch_clock_source_select,
	input wire logic sub_clock_tick,
	// result
	output logic watch_tick
);

	logic phase_r;
	logic main_en;
	logic [WIT_MAIN_DIV_LOG2-1:0] div_r;
	logic main_tick;

	// main system clock is the oscillator or half of it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phase_r <= 1'b0;
		end else begin
			phase_r <= ~phase_r;
		end
	end
	assign main_en = ~main_clock_div2 | phase_r;

	// divide the main system clock by 2^7
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_r <= '0;
		end else if (main_en) begin
			div_r <= div_r + 7'h01;
		end
	end
	assign main_tick = main_en && (div_r == WIT_MAIN_DIV_LAST);

	// source select; switching mid-count may shorten one period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			watch_tick <= 1'b0;
		end else begin
			watch_tick <= watch_clock_source_select ? sub_clock_tick
				: main_tick;
		end
	end

endmodule : wit_clock_gen

// file: wit_ctrl_reg.sv
// wit_ctrl_reg: the 8-bit watch mode control register.
// assumes one write request per cycle; byte write wins over bit write.
module wit_ctrl_reg import wit_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// cpu write
	input wire wit_write_type wr,
	// register contents
	output logic [7:0] ctrl_q
);

	logic hit;

	assign hit = (wr.addr == WIT_CTRL_ADDR);

	// byte and bit writes; bit 7 never stores a one
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= WIT_CTRL_RESET;
		end else if (hit && wr.byte_we) begin
			ctrl_q <= wr.data & WIT_CTRL_MASK;
		end else if (hit && wr.bit_we) begin
			ctrl_q[wr.bit_sel] <= wr.data[0] & WIT_CTRL_MASK[wr.bit_sel];
		end
	end

endmodule : wit_ctrl_reg

// file: wit_pkg.sv
// wit_pkg: constants and carrier types of the watch interval timer.
// assumes: one 100 MHz clock; the cpu drives register writes synchronously.
package wit_pkg;

	// register placement and reset value
	localparam logic [15:0] WIT_CTRL_ADDR = 16'hff4a;
	localparam logic [7:0] WIT_CTRL_RESET = 8'h00;
	// bit 7 is fixed at zero
	localparam logic [7:0] WIT_CTRL_MASK = 8'h7f;

	// field positions inside the mode control register
	localparam int WIT_FAST_BIT = 0;
	localparam int WIT_PRE_EN_BIT = 1;
	localparam int WIT_CNT_EN_BIT = 2;
	localparam int WIT_PERIOD_BIT = 3;
	localparam int WIT_IVL_LSB = 4;
	localparam int WIT_IVL_MSB = 6;

	// chain widths and divide figures
	localparam int WIT_MAIN_DIV_LOG2 = 7;
	localparam logic [6:0] WIT_MAIN_DIV_LAST = 7'h7f;
	localparam int WIT_PRE_W = 9;
	localparam int WIT_CNT_W = 5;
	localparam logic [4:0] WIT_FAST_LAST = 5'h1f;
	localparam logic [4:0] WIT_CNT_LAST = 5'h1f;
	localparam logic [3:0] WIT_CNT_HALF_LAST = 4'hf;
	localparam int WIT_IVL_BASE_LOG2 = 4;
	localparam logic [2:0] WIT_IVL_MAX_CODE = 3'h5;

	// one register write from the cpu, byte or single bit
	typedef struct packed {
		logic byte_we;
		logic bit_we;
		logic [2:0] bit_sel;
		logic [7:0] data;
		logic [15:0] addr;
	} wit_write_type;

	// decoded mode control fields
	typedef struct packed {
		logic [2:0] interval_select;
		logic flag_period_select;
		logic counter_enable;
		logic prescaler_enable;
		logic fast_feed_select;
	} wit_ctrl_type;

endpackage : wit_pkg

// file: wit_watch_timer.sv
// wit_watch_timer: watch timer with interval function, top level.
// assumes cpu writes and reads are synchronous single-cycle strobes.
module wit_watch_timer import wit_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// cpu register access
	input wire wit_write_type reg_wr,
	input wire logic [15:0] rd_addr,
	output logic [7:0] rd_data,
	// clock selection from shared registers and the subsystem oscillator
	input wire logic main_clock_div2,
	input wire logic watch_clock_source_select,
	input wire logic sub_clock_tick,
	// interrupt side
	input wire logic watch_interrupt_mask,
	input wire logic flag_clear,
	output logic watch_interrupt_flag,
	output logic interval_interrupt,
	output logic standby_release,
	// status
	output logic [WIT_CNT_W-1:0] counter_value
);

	logic [7:0] ctrl_q;
	wit_ctrl_type ctrl;
	logic watch_tick;
	logic [WIT_PRE_W-1:0] pre_r;
	logic [WIT_CNT_W-1:0] cnt_r;
	logic pre_wrap;
	logic fast_evt;
	logic norm_evt;
	logic watch_evt;
	logic ivl_evt;
	logic flag_nxt;

	// true when code is at most 5 and the low 4+code prescaler bits are all ones
	function automatic logic interval_hit(input logic [WIT_PRE_W-1:0] p,
		input logic [2:0] code);
		logic hit;
		hit = (code <= WIT_IVL_MAX_CODE);
		for (int i = 0; i < WIT_PRE_W; i++) begin
			if (i < WIT_IVL_BASE_LOG2 + int'(code)) begin
				hit = hit & p[i];
			end
		end
		return hit;
	endfunction : interval_hit

	// mode control register
	wit_ctrl_reg u_ctrl (
		.clk(clk),
		.reset(reset),
		.wr(reg_wr),
		.ctrl_q(ctrl_q)
	);
	assign ctrl = wit_ctrl_type'(ctrl_q[WIT_IVL_MSB:WIT_FAST_BIT]);

	// watch clock enable
	wit_clock_gen u_clk (
		.clk(clk),
		.reset(reset),
		.main_clock_div2(main_clock_div2),
		.watch_clock_source_select(watch_clock_source_select),
		.sub_clock_tick(sub_clock_tick),
		.watch_tick(watch_tick)
	);

	// prescaler; disabled means held at zero, so each clear costs time
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pre_r <= '0;
		end else if (!ctrl.prescaler_enable) begin
			pre_r <= '0;
		end else if (watch_tick) begin
			pre_r <= pre_r + 9'h001;
		end
	end
	assign pre_wrap = watch_tick && ctrl.prescaler_enable && (&pre_r);

	// 5-bit counter, cleared without touching the prescaler
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r <= '0;
		end else if (!ctrl.counter_enable) begin
			cnt_r <= '0;
		end else if (pre_wrap) begin
			cnt_r <= cnt_r + 5'h01;
		end
	end

	// flag period events
	assign fast_evt = watch_tick && ctrl.prescaler_enable &&
		ctrl.counter_enable && (pre_r[4:0] == WIT_FAST_LAST);
	assign norm_evt = pre_wrap && ctrl.counter_enable &&
		(ctrl.flag_period_select ? (cnt_r[3:0] == WIT_CNT_HALF_LAST)
		: (cnt_r == WIT_CNT_LAST));
	assign watch_evt = ctrl.fast_feed_select ? fast_evt : norm_evt;

	// interval events follow the prescaler alone
	assign ivl_evt = watch_tick && ctrl.prescaler_enable &&
		interval_hit(pre_r, ctrl.interval_select);

	// watch flag: a set in the clearing cycle wins
	assign flag_nxt = watch_evt | (watch_interrupt_flag & ~flag_clear);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			watch_interrupt_flag <= 1'b0;
		end else begin
			watch_interrupt_flag <= flag_nxt;
		end
	end

	// dedicated interval request line, one-cycle pulse
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			interval_interrupt <= 1'b0;
		end else begin
			interval_interrupt <= ivl_evt;
		end
	end

	// standby release follows the unmasked flag
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			standby_release <= 1'b0;
		end else begin
			standby_release <= flag_nxt & ~watch_interrupt_mask;
		end
	end

	// read port and counter status
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_data <= '0;
			counter_value <= '0;
		end else begin
			rd_data <= (rd_addr == WIT_CTRL_ADDR) ? ctrl_q : 8'h00;
			counter_value <= cnt_r;
		end
	end

	// checks
	reset_clear_a: assert property (@(posedge clk)
		reset |-> ctrl_q == WIT_CTRL_RESET)
		else $error("mode register not zero in reset");

	bit_write_a: assert property (@(posedge clk) disable iff (reset)
		(reg_wr.addr == WIT_CTRL_ADDR && reg_wr.bit_we && !reg_wr.byte_we &&
		reg_wr.bit_sel != 3'h7) |=> (ctrl_q[$past(reg_wr.bit_sel)] ==
		$past(reg_wr.data[0])) && ((ctrl_q ^ $past(ctrl_q)) &
		~(8'h01 << $past(reg_wr.bit_sel))) == 8'h00)
		else $error("bit write touched wrong bits");

	bit7_zero_a: assert property (@(posedge clk) disable iff (reset)
		ctrl_q[7] == 1'b0 && (rd_data[7] == 1'b0))
		else $error("bit 7 not zero");

	pre_hold_a: assert property (@(posedge clk) disable iff (reset)
		!ctrl.prescaler_enable |=> pre_r == '0 && !interval_interrupt)
		else $error("prescaler runs while disabled");

	cnt_clear_a: assert property (@(posedge clk) disable iff (reset)
		!ctrl.counter_enable |=> cnt_r == '0 ##1 counter_value == '0)
		else $error("counter not cleared");

	norm_flag_a: assert property (@(posedge clk) disable iff (reset)
		(pre_wrap && ctrl.counter_enable && !ctrl.fast_feed_select &&
		!ctrl.flag_period_select && cnt_r == WIT_CNT_LAST)
		|=> watch_interrupt_flag)
		else $error("flag missed at 2^14");

	fast_flag_a: assert property (@(posedge clk) disable iff (reset)
		(watch_tick && ctrl.fast_feed_select && ctrl.prescaler_enable &&
		ctrl.counter_enable && pre_r[4:0] == WIT_FAST_LAST)
		|=> watch_interrupt_flag)
		else $error("fast feed flag missed");

	ivl_code_a: assert property (@(posedge clk) disable iff (reset)
		ctrl.interval_select > WIT_IVL_MAX_CODE |=> !interval_interrupt)
		else $error("interval from prohibited code");

	ivl_pulse_a: assert property (@(posedge clk) disable iff (reset)
		(watch_tick && ctrl.prescaler_enable && ctrl.interval_select == 3'h0
		&& pre_r[3:0] == 4'hf) |=> interval_interrupt ##1 !interval_interrupt)
		else $error("interval pulse wrong");

	standby_a: assert property (@(posedge clk) disable iff (reset)
		standby_release |-> watch_interrupt_flag && !$past(watch_interrupt_mask))
		else $error("standby release without unmasked flag");

endmodule : wit_watch_timer
